// [rtl/secp_defines.svh]
/*
  Constants of the serial engine command processor: op-codes, register
  offsets, field positions, reset values and timing counts.
  Assumes inclusion by bare name from the core and the bench top.
*/
`ifndef SECP_DEFINES_SVH
`define SECP_DEFINES_SVH
`define SECP_CLK_NS        25
`define SECP_MS_NS         1000000
`define SECP_PRE_DIV       3'h4
`define SECP_BAD_CMD       8'hFA
`define SECP_MODE_RESET    8'h00
`define SECP_MODE_ENABLE   8'h02
`define SECP_OP_SHIFT      3'h1
`define SECP_OP_SET_PINS   8'h80
`define SECP_OP_READ_PINS  8'h81
`define SECP_OP_LOOP_ON    8'h84
`define SECP_OP_LOOP_OFF   8'h85
`define SECP_OP_DIVISOR    8'h86
`define SECP_OP_DIV5_OFF   8'h8A
`define SECP_OP_DIV5_ON    8'h8B
`define SECP_OP_3PH_ON     8'h8C
`define SECP_OP_3PH_OFF    8'h8D
`define SECP_OP_ADAPT_ON   8'h96
`define SECP_OP_ADAPT_OFF  8'h97
`define SECP_SH_TXF        0
`define SECP_SH_RXF        1
`define SECP_SH_RX         2
`define SECP_SH_TX         3
`define SECP_SH_LSB        4
`define SECP_PIN_SCK       0
`define SECP_PIN_DOUT      1
`define SECP_PIN_DIN       2
`define SECP_PIN_RTCK      7
`define SECP_REG_MODE      8'h00
`define SECP_REG_STATUS    8'h04
`define SECP_REG_IRQ_STAT  8'h08
`define SECP_REG_IRQ_MASK  8'h0C
`define SECP_REG_LATENCY   8'h10
`define SECP_REG_IN_SIZE   8'h14
`define SECP_REG_OUT_SIZE  8'h18
`define SECP_REG_CLKCFG    8'h1C
`define SECP_IRQ_BAD       0
`define SECP_IRQ_FLUSH     1
`define SECP_LAT_RST       8'h10
`define SECP_SIZE_MIN      17'h00040
`define SECP_SIZE_MAX      17'h10000
`define SECP_RESP_OK       2'h0
`define SECP_RESP_ERR      2'h2
`endif

// [rtl/secp_pkg.sv]
/*
  Types of the serial engine command processor.
  Assumes secp_defines.svh is on the include path.
*/
`default_nettype none
package secp_pkg;
  typedef enum logic [2:0] {
    SECP_OP, SECP_ARG, SECP_LOAD, SECP_BIT, SECP_RXE, SECP_EMIT
  } secp_state_t;
endpackage : secp_pkg
`default_nettype wire

// [rtl/secp_core.sv]
/*
  Serial engine command processor: decodes a byte stream of op-codes and
  parameters, shifts serial data, drives and reads pins, and returns bytes
  with latency and size flushing. Registers over AXI4-Lite.
  Assumes byte streams and pins synchronous to clk; pin buffers outside.
*/
// The register addresses and register access over AXI4-Lite were decided locally.
`default_nettype none
`include "secp_defines.svh"
module secp_core #(
  parameter int MS_CYCLES = `SECP_MS_NS / `SECP_CLK_NS
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  output logic [7:0]       rsp_data,
  output logic             rsp_valid,
  input  wire logic        rsp_ready,
  output logic             rsp_flush,
  input  wire logic [7:0]  pin_in,
  output logic [7:0]       pin_out,
  output logic [7:0]       pin_oe,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      o[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
    return o;
  endfunction : merge

  // Out-of-range sizes are clamped rather than refused
  function automatic logic [16:0] clamp(input logic [31:0] v);
    if (v < 32'(`SECP_SIZE_MIN)) return `SECP_SIZE_MIN;
    if (v > 32'(`SECP_SIZE_MAX)) return `SECP_SIZE_MAX;
    return v[16:0];
  endfunction : clamp

  function automatic logic [1:0] arg_count(input logic [7:0] op);
    if (op[7:5] == `SECP_OP_SHIFT || op == `SECP_OP_SET_PINS || op == `SECP_OP_DIVISOR)
      return 2'h2;
    return 2'h0;
  endfunction : arg_count

  function automatic logic known_op(input logic [7:0] op);
    case (op)
      `SECP_OP_SET_PINS, `SECP_OP_READ_PINS, `SECP_OP_LOOP_ON, `SECP_OP_LOOP_OFF,
      `SECP_OP_DIVISOR, `SECP_OP_DIV5_OFF, `SECP_OP_DIV5_ON, `SECP_OP_3PH_ON,
      `SECP_OP_3PH_OFF, `SECP_OP_ADAPT_ON, `SECP_OP_ADAPT_OFF: return 1'b1;
      default: return op[7:5] == `SECP_OP_SHIFT;
    endcase
  endfunction : known_op

  // Register bus state
  logic        aw_h, w_h;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [7:0]  mode;
  logic [1:0]  irq_stat, irq_mask;
  logic [7:0]  latency;
  logic [16:0] in_size, out_size;
  // Engine state
  secp_pkg::secp_state_t state;
  logic [7:0]  op, arg0, sh, rx_sh, em_data, em_next;
  logic [1:0]  argn;
  logic        em_more;
  logic [15:0] len, divisor, div_cnt;
  logic [2:0]  pre_cnt, bitn;
  logic [1:0]  half;
  logic        loopback, div5, three_ph, adaptive, bad_ev;
  // Return path state
  logic [16:0] rsp_cnt;
  logic [31:0] ms_cnt;
  logic [7:0]  lat_cnt;

  wire wr_go    = aw_h && w_h && !s_axi_bvalid;
  wire [31:0] wr_val = merge(32'h0, wdata_q, wstrb_q);
  wire wr_mode  = wr_go && awaddr_q == `SECP_REG_MODE;
  wire wr_istat = wr_go && awaddr_q == `SECP_REG_IRQ_STAT;
  wire wr_imask = wr_go && awaddr_q == `SECP_REG_IRQ_MASK;
  wire wr_lat   = wr_go && awaddr_q == `SECP_REG_LATENCY;
  wire wr_isz   = wr_go && awaddr_q == `SECP_REG_IN_SIZE;
  wire wr_osz   = wr_go && awaddr_q == `SECP_REG_OUT_SIZE;
  wire wr_ok    = wr_mode | wr_istat | wr_imask | wr_lat | wr_isz | wr_osz;
  wire eng_srst = wr_mode && wr_val[7:0] == `SECP_MODE_RESET;
  wire eng_en   = mode == `SECP_MODE_ENABLE;

  wire [31:0] rd_clk = {13'h0, adaptive, three_ph, div5, divisor};
  wire [31:0] rd_sts = {26'h0, eng_en, state != secp_pkg::SECP_OP, 1'b0, state};
  wire rd_hit = s_axi_araddr inside {`SECP_REG_MODE, `SECP_REG_STATUS,
    `SECP_REG_IRQ_STAT, `SECP_REG_IRQ_MASK, `SECP_REG_LATENCY, `SECP_REG_IN_SIZE,
    `SECP_REG_OUT_SIZE, `SECP_REG_CLKCFG};
  wire [31:0] rd_mux =
    s_axi_araddr == `SECP_REG_MODE     ? {24'h0, mode}     :
    s_axi_araddr == `SECP_REG_STATUS   ? rd_sts            :
    s_axi_araddr == `SECP_REG_IRQ_STAT ? {30'h0, irq_stat} :
    s_axi_araddr == `SECP_REG_IRQ_MASK ? {30'h0, irq_mask} :
    s_axi_araddr == `SECP_REG_LATENCY  ? {24'h0, latency}  :
    s_axi_araddr == `SECP_REG_IN_SIZE  ? {15'h0, in_size}  :
    s_axi_araddr == `SECP_REG_OUT_SIZE ? {15'h0, out_size} :
    s_axi_araddr == `SECP_REG_CLKCFG   ? rd_clk            : 32'h0;

  // Write channels taken in either order; response after both
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SECP_RESP_OK;
      aw_h          <= 1'b0;
      w_h           <= 1'b0;
      awaddr_q      <= 8'h0;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_h          <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_h          <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SECP_RESP_OK : `SECP_RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_h          <= 1'b0;
        w_h           <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `SECP_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? `SECP_RESP_OK : `SECP_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Sticky events: a new event wins over a same-cycle clear
  wire [1:0] ev = {rsp_flush, bad_ev};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode     <= `SECP_MODE_RESET;
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
      latency  <= `SECP_LAT_RST;
      in_size  <= `SECP_SIZE_MAX;
      out_size <= `SECP_SIZE_MAX;
      irq      <= 1'b0;
    end else begin
      if (wr_mode) mode <= wr_val[7:0];
      if (wr_imask) irq_mask <= wr_val[1:0];
      if (wr_lat) latency <= wr_val[7:0];
      if (wr_isz) in_size <= clamp(wr_val);
      if (wr_osz) out_size <= clamp(wr_val);
      irq_stat <= (irq_stat & ~(wr_istat ? wr_val[1:0] : 2'h0)) | ev;
      irq      <= |((irq_stat | ev) & irq_mask);
    end
  end

  // Base clock: 40 MHz or 8 MHz (clk or clk / 5), emulated by enables of clk
  wire base_tick = !div5 || pre_cnt == `SECP_PRE_DIV;
  wire half_tick = base_tick && div_cnt == divisor;
  wire sck       = pin_out[`SECP_PIN_SCK];
  wire rt_ok     = !adaptive || pin_in[`SECP_PIN_RTCK] == sck;
  wire din       = loopback ? pin_out[`SECP_PIN_DOUT] : pin_in[`SECP_PIN_DIN];
  wire rise      = !sck;
  wire tx_edge   = op[`SECP_SH_TX] && (rise != op[`SECP_SH_TXF]);
  wire rx_edge   = op[`SECP_SH_RX] && (rise != op[`SECP_SH_RXF]);
  wire [2:0] bix = op[`SECP_SH_LSB] ? bitn : 3'h7 - bitn;
  wire can_emit  = !rsp_valid || rsp_ready;
  wire take      = cmd_valid && cmd_ready;
  wire want_byte = eng_en && (state == secp_pkg::SECP_OP || state == secp_pkg::SECP_ARG ||
                              state == secp_pkg::SECP_LOAD);
  // Next step after a byte: fetch transmit data or shift straight away
  secp_pkg::secp_state_t after_byte;
  assign after_byte = op[`SECP_SH_TX] ? secp_pkg::SECP_LOAD : secp_pkg::SECP_BIT;
  wire more      = len != 16'h0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt <= 3'h0;
      div_cnt <= 16'h0;
    end else begin
      pre_cnt <= (eng_srst || base_tick) ? 3'h0 : pre_cnt + 3'h1;
      div_cnt <= (eng_srst || half_tick) ? 16'h0 : div_cnt + 16'(base_tick);
    end
  end

  // Command engine; one byte per two cycles keeps cmd_ready a flop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= secp_pkg::SECP_OP;
      {op, arg0, sh, rx_sh, em_data, em_next} <= 48'h0;
      {argn, em_more, len, divisor, bitn, half} <= 40'h0;
      {loopback, three_ph, adaptive, bad_ev, cmd_ready} <= 5'h0;
      div5    <= 1'b1;
      pin_out <= 8'h0;
      pin_oe  <= 8'h0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h0;
    end else if (eng_srst) begin
      state <= secp_pkg::SECP_OP;
      {loopback, three_ph, adaptive, bad_ev, cmd_ready} <= 5'h0;
      {bitn, half, len, divisor} <= 37'h0;
      div5   <= 1'b1;
      pin_oe <= 8'h0;
    end else begin
      bad_ev    <= 1'b0;
      cmd_ready <= want_byte && !take;
      if (rsp_valid && rsp_ready) rsp_valid <= 1'b0;
      case (state)
        secp_pkg::SECP_OP: if (take) begin
          op   <= cmd_data;
          argn <= arg_count(cmd_data);
          if (!known_op(cmd_data)) begin
            bad_ev  <= 1'b1;
            em_data <= `SECP_BAD_CMD;
            em_next <= cmd_data;
            em_more <= 1'b1;
            state   <= secp_pkg::SECP_EMIT;
          end else if (arg_count(cmd_data) != 2'h0) begin
            state <= secp_pkg::SECP_ARG;
          end else begin
            case (cmd_data)
              `SECP_OP_READ_PINS: begin
                em_data <= pin_in;
                em_more <= 1'b0;
                state   <= secp_pkg::SECP_EMIT;
              end
              `SECP_OP_LOOP_ON:   loopback <= 1'b1;
              `SECP_OP_LOOP_OFF:  loopback <= 1'b0;
              `SECP_OP_DIV5_ON:   div5 <= 1'b1;
              `SECP_OP_DIV5_OFF:  div5 <= 1'b0;
              `SECP_OP_3PH_ON:    three_ph <= 1'b1;
              `SECP_OP_3PH_OFF:   three_ph <= 1'b0;
              `SECP_OP_ADAPT_ON:  adaptive <= 1'b1;
              `SECP_OP_ADAPT_OFF: adaptive <= 1'b0;
              default: ;
            endcase
          end
        end
        secp_pkg::SECP_ARG: if (take) begin
          argn <= argn - 2'h1;
          arg0 <= cmd_data;
          if (argn == 2'h1) begin
            if (op == `SECP_OP_SET_PINS) begin
              pin_out <= arg0;
              pin_oe  <= cmd_data;
              state   <= secp_pkg::SECP_OP;
            end else if (op == `SECP_OP_DIVISOR) begin
              divisor <= {cmd_data, arg0};
              state   <= secp_pkg::SECP_OP;
            end else begin
              len   <= {cmd_data, arg0};
              bitn  <= 3'h0;
              half  <= 2'h0;
              state <= after_byte;
            end
          end
        end
        secp_pkg::SECP_LOAD: if (take) begin
          sh    <= cmd_data;
          state <= secp_pkg::SECP_BIT;
        end
        secp_pkg::SECP_BIT: if (half_tick && rt_ok) begin
          if (half == 2'h2) begin
            half <= 2'h0;
          end else begin
            pin_out[`SECP_PIN_SCK] <= !sck;
            if (tx_edge) pin_out[`SECP_PIN_DOUT] <= sh[bix];
            if (rx_edge) rx_sh[bix] <= din;
            half <= (half == 2'h0) ? 2'h1 : (three_ph ? 2'h2 : 2'h0);
          end
          if (half == 2'h2 || (half == 2'h1 && !three_ph)) begin
            bitn <= bitn + 3'h1;
            if (bitn == 3'h7) begin
              if (op[`SECP_SH_RX]) state <= secp_pkg::SECP_RXE;
              else if (!more) state <= secp_pkg::SECP_OP;
              else begin
                len   <= len - 16'h1;
                state <= after_byte;
              end
            end
          end
        end
        secp_pkg::SECP_RXE: if (can_emit) begin
          rsp_valid <= 1'b1;
          rsp_data  <= rx_sh;
          len       <= len - 16'(more);
          state     <= !more ? secp_pkg::SECP_OP : after_byte;
        end
        secp_pkg::SECP_EMIT: if (can_emit) begin
          rsp_valid <= 1'b1;
          rsp_data  <= em_data;
          em_data   <= em_next;
          em_more   <= 1'b0;
          if (!em_more) state <= secp_pkg::SECP_OP;
        end
        default: state <= secp_pkg::SECP_OP;
      endcase
    end
  end

  // Return packets end at the size limit or when the latency expires
  wire rsp_xfer = rsp_valid && rsp_ready;
  wire size_hit = rsp_xfer && (rsp_cnt + 17'h1 >= in_size);
  wire ms_tick  = ms_cnt == 32'(MS_CYCLES - 1);
  wire lat_hit  = rsp_cnt != 17'h0 && ms_tick && lat_cnt + 8'h1 >= latency;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_cnt   <= 17'h0;
      ms_cnt    <= 32'h0;
      lat_cnt   <= 8'h0;
      rsp_flush <= 1'b0;
    end else begin
      rsp_flush <= size_hit || lat_hit;
      ms_cnt    <= (ms_tick || rsp_cnt == 17'h0) ? 32'h0 : ms_cnt + 32'h1;
      if (size_hit || lat_hit || rsp_cnt == 17'h0) lat_cnt <= 8'h0;
      else if (ms_tick) lat_cnt <= lat_cnt + 8'h1;
      if (size_hit || lat_hit) rsp_cnt <= 17'(rsp_xfer && !size_hit);
      else rsp_cnt <= rsp_cnt + 17'(rsp_xfer);
    end
  end
endmodule : secp_core
`default_nettype wire

// [testbench/secp_core_monitor.sv]
/*
  Checker of the command processor's stream and register bus handshakes.
  Assumes it is bound to secp_core and sees only that module's ports.
*/
`default_nettype none
module secp_core_monitor #(
  parameter int MS_CYCLES = 40000
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [7:0]  rsp_data,
  input wire logic        rsp_valid,
  input wire logic        rsp_ready,
  input wire logic        rsp_flush,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_cmd_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_cmd_take_gap: assert property (s_cmd_take |=> !cmd_ready)
    else $error("cmd_ready high right after a take");
  a_rsp_byte_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("return byte lost or changed while stalled");
  a_flush_one_pulse: assert property (rsp_flush |=> !rsp_flush)
    else $error("flush longer than one cycle");
  a_write_answer: assert property (s_wr_take |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after take");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after take");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule : secp_core_monitor
bind secp_core secp_core_monitor #(.MS_CYCLES(MS_CYCLES)) mon_u (.clk, .arst_n, .cmd_valid,
  .cmd_ready, .rsp_data, .rsp_valid, .rsp_ready, .rsp_flush, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// [testbench/secp_host_model.sv]
/*
  Host side of the return stream: takes bytes with stalls, keeps their order.
  Assumes the return stream is synchronous to clk.
*/
`default_nettype none
module secp_host_model (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] rsp_data,
  input  wire logic       rsp_valid,
  output logic            rsp_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];
  logic [1:0] phase;
  // Ready one cycle in three, so the engine must hold its bytes
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase     <= 2'h0;
      rsp_ready <= 1'b0;
    end else begin
      phase     <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      rsp_ready <= (phase == 2'h2);
      if (rsp_valid && rsp_ready) got_q.push_back(rsp_data);
    end
  end
endmodule : secp_host_model
`default_nettype wire

// [testbench/secp_core_tb_top.sv]
/*
  Bench top: sends command streams, drives register cycles, checks returns and pins.
  Assumes secp_core, its defines, the host model and the bound monitor.
*/
`default_nettype none
`include "secp_defines.svh"
module secp_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, arst_n, cmd_valid, cmd_ready, rsp_valid, rsp_ready, rsp_flush, irq;
  logic [7:0]  cmd_data, rsp_data, pin_out, pin_oe, s_axi_awaddr, s_axi_araddr, sr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  wire logic [7:0] pin_in = {pin_out[0], 4'h5, ~pin_out[1], 2'h2};
  int          n_mismatch = 0, num_checks = 0, n_flush = 0;
  time         t_fall[2];
  logic [41:0] regs[6] = '{{8'h00, 32'h0, 2'h0}, {8'h10, 32'h10, 2'h0},
    {8'h14, 32'h10000, 2'h0}, {8'h18, 32'h10000, 2'h0}, {8'h1C, 32'h10000, 2'h0},
    {8'h40, 32'h0, 2'h2}};
  logic [39:0] clk_rows[7] = '{{8'h8A, 32'h2}, {8'h8C, 32'h20002}, {8'h96, 32'h60002},
    {8'h8B, 32'h70002}, {8'h8D, 32'h50002}, {8'h97, 32'h10002}, {8'h8A, 32'h2}};
  secp_core #(.MS_CYCLES(20)) dut_u (.clk, .arst_n, .cmd_data, .cmd_valid, .cmd_ready,
    .rsp_data, .rsp_valid, .rsp_ready, .rsp_flush, .pin_in, .pin_out, .pin_oe, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  secp_host_model host_u (.clk, .arst_n, .rsp_data, .rsp_valid, .rsp_ready);
  always #12.5 clk = ~clk;
  always @(posedge clk) if (rsp_flush === 1'b1) n_flush <= n_flush + 1;
  // Sampled on the falling serial clock, where rising-edge data is settled
  always @(negedge pin_out[0]) begin
    sr = {sr[6:0], pin_out[1]};
    t_fall[0] = t_fall[1];
    t_fall[1] = $time;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask : wr
  task automatic rc(input string w, input logic [7:0] a, input logic [31:0] e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    chk(w, d, e);
  endtask : rc
  task automatic snd(input logic [7:0] b);
    cmd_data  <= b;
    cmd_valid <= 1'b1;
    do @(posedge clk); while (!cmd_ready);
  endtask : snd
  // Engine refuses bytes while shifting or returning, so ready means done
  task automatic wait_rdy();
    int t = 0;
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk);
      t++;
    end while (!cmd_ready && t < 3000);
  endtask : wait_rdy
  task automatic exp_rsp(input string w, input logic [7:0] e, input logic c);
    int t = 0;
    while (host_u.got_q.size() == 0 && t < 4000) begin
      @(posedge clk);
      t++;
    end
    if (host_u.got_q.size() == 0) chk(w, 32'h100, {24'h0, e});
    else if (c) chk(w, {24'h0, host_u.got_q.pop_front()}, {24'h0, e});
    else void'(host_u.got_q.pop_front());
  endtask : exp_rsp
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    #(25 * 60000);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {clk, arst_n, cmd_valid, cmd_data, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    // Response ready held high: every answer is taken at the edge it is seen
    s_axi_bready <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge clk);
    foreach (regs[i]) begin
      rc("reg", regs[i][41:34], regs[i][33:2]);
      chk("resp", r, regs[i][1:0]);
    end
    wr(`SECP_REG_LATENCY, 32'h1);
    wr(`SECP_REG_IN_SIZE, 32'h10);
    rc("in_size", `SECP_REG_IN_SIZE, 32'h40);
    wr(`SECP_REG_OUT_SIZE, 32'h20000);
    rc("out_size", `SECP_REG_OUT_SIZE, 32'h10000);
    wr(`SECP_REG_MODE, 32'h0);
    wr(`SECP_REG_MODE, 32'h2);
    chk("oe", pin_oe, 0);
    wr(`SECP_REG_IRQ_MASK, 32'h1);
    snd(8'hAB);
    snd(`SECP_OP_READ_PINS);
    cmd_valid <= 1'b0;
    exp_rsp("bad", `SECP_BAD_CMD, 1);
    exp_rsp("echo", 8'hAB, 1);
    exp_rsp("pins", 8'h2E, 1);
    chk("irq", irq, 1);
    wr(`SECP_REG_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", irq, 0);
    wr(`SECP_REG_IRQ_MASK, 32'h1);
    wr(`SECP_REG_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq cleared", irq, 0);
    snd(`SECP_OP_SET_PINS);
    snd(8'h40);
    snd(8'h4B);
    snd(`SECP_OP_DIVISOR);
    snd(8'h02);
    snd(8'h00);
    wait_rdy();
    chk("pin_oe", pin_oe, 8'h4B);
    chk("pin_out", pin_out, 8'h40);
    foreach (clk_rows[i]) begin
      snd(clk_rows[i][39:32]);
      wait_rdy();
      rc("clkcfg", `SECP_REG_CLKCFG, clk_rows[i][31:0]);
    end
    snd(`SECP_OP_LOOP_ON);
    for (int op = 0; op < 32; op++) begin
      logic [7:0] b, br;
      b = 8'hC5 ^ 8'(op);
      br = {<<{b}};
      snd(8'h20 | 8'(op));
      snd(8'h00);
      snd(8'h00);
      if (op[3]) snd(b);
      wait_rdy();
      if (op[2]) exp_rsp("loopback", b, op[3] && op[1] && !op[0]);
      if (op[3] && !op[0]) chk("dout", sr, op[4] ? br : b);
    end
    chk("period", 32'(t_fall[1] - t_fall[0]), 32'd150);
    chk("flush", n_flush != 0, 1);
    wr(`SECP_REG_MODE, 32'h0);
    repeat (2) @(posedge clk);
    chk("oe reset", pin_oe, 0);
    chk("gpio kept", pin_out[6], 1);
    chk("disabled", cmd_ready, 0);
    rc("clkcfg reset", `SECP_REG_CLKCFG, 32'h10000);
    tally_and_finish();
  end
endmodule : secp_core_tb_top
`default_nettype wire
